/* src/aoad_defs.svh */
// Offsets, field positions, reset values and widths of the address output block.
// Assumes inclusion by bare name from the package and modules.
`ifndef AOAD_DEFS_SVH
`define AOAD_DEFS_SVH

`define AOAD_PADDR_W       12
`define AOAD_DATA_W        32
`define AOAD_OFS_ADDR_EN   12'h000
`define AOAD_OFS_PORT_DIR  12'h004
`define AOAD_OFS_PORT_DATA 12'h008
`define AOAD_OFS_CS_DIR    12'h00C
`define AOAD_OFS_STATUS    12'h010

`define AOAD_CTRL_W        8
`define AOAD_AE_MSB        3
`define AOAD_AE_LSB        0
`define AOAD_AE_ALL        4'hF
`define AOAD_AE_RST_ROM    4'hD
`define AOAD_AE_RST_NONE   4'h0
`define AOAD_CTRL_RST      8'h00

`define AOAD_MODE_W        3
`define AOAD_MODE_4        3'h4
`define AOAD_MODE_5        3'h5

`define AOAD_ADDR_W        24
`define AOAD_NUM_APINS     16
`define AOAD_APIN_BASE     8
`define AOAD_NUM_CS        6
`define AOAD_AREA_W        3
`define AOAD_AREA_MSB      23
`define AOAD_AREA_LSB      21

`define AOAD_ST_AREA_LSB   16
`define AOAD_ST_AREA_MSB   18
`define AOAD_ST_ACC_BIT    19
`define AOAD_ST_CS_LSB     20
`define AOAD_ST_CS_MSB     25

`endif

/* src/aoad_pkg.sv */
// Types shared by the address output block.
// Assumes the defines header sits beside it on the include path.
`include "aoad_defs.svh"

package aoad_pkg;

	typedef struct packed {
		logic                     access;
		logic [`AOAD_ADDR_W-1:0]  addr;
	} aoad_ext_bus_t;

	typedef struct packed {
		logic [`AOAD_NUM_APINS-1:0] out;
		logic [`AOAD_NUM_APINS-1:0] oe;
	} aoad_apin_t;

endpackage

/* src/aoad_area_decode.sv */
// Area decoder: splits the 24-bit space into eight 2-Mbyte areas.
// Assumes the access flag is high for a whole external-space access.
`timescale 1ns/1ps
`default_nettype none
`include "aoad_defs.svh"

module aoad_area_decode
	import aoad_pkg::*;
(
	input  wire aoad_ext_bus_t              bus,
	output logic [`AOAD_AREA_W-1:0]        area,
	output logic [`AOAD_NUM_CS-1:0]        cs_n
);

	assign area = bus.addr[`AOAD_AREA_MSB:`AOAD_AREA_LSB];

	// Areas 6 and 7 decode but own no select line
	for (genvar g = 0; g < `AOAD_NUM_CS; g++) begin : g_cs
		assign cs_n[g] = ~(bus.access && (area == `AOAD_AREA_W'(g)));
	end

endmodule

`default_nettype wire

/* src/aoad_top.sv */
// Address pin enable, port fallback and area chip selects, behind an APB slave.
// Assumes a zero-wait APB master on core_clk and a mode strap stable at reset release.
`timescale 1ns/1ps
`default_nettype none
`include "aoad_defs.svh"

module aoad_top
	import aoad_pkg::*;
(
	input  wire logic                      core_clk,
	input  wire logic                      arst_n,
	input  wire logic [`AOAD_MODE_W-1:0]   op_mode,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [`AOAD_PADDR_W-1:0]  paddr,
	input  wire logic [`AOAD_DATA_W-1:0]   pwdata,
	output logic [`AOAD_DATA_W-1:0]        prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire aoad_ext_bus_t             ext_bus,
	output var aoad_apin_t                 apin,
	output logic [`AOAD_NUM_CS-1:0]        cs_pin_n,
	output logic [`AOAD_NUM_CS-1:0]        cs_pin_oe
);

	logic [`AOAD_CTRL_W-1:0]     address_pin_enable_ctrl;
	logic [`AOAD_NUM_APINS-1:0]  port_dir;
	logic [`AOAD_NUM_APINS-1:0]  port_data;
	logic [`AOAD_NUM_CS-1:0]     cs_dir;
	logic                        strap_done;
	logic [3:0]                  ae_field;
	logic [`AOAD_NUM_APINS-1:0]  addr_en;
	logic [`AOAD_AREA_W-1:0]     area;
	logic [`AOAD_NUM_CS-1:0]     next_cs_n;
	logic                        setup;
	logic                        wr_fire;
	logic                        hit;
	logic [`AOAD_DATA_W-1:0]     next_rdata;
	aoad_apin_t                  next_apin;
	logic [`AOAD_NUM_APINS-1:0]  next_pin_out;
	logic [`AOAD_NUM_APINS-1:0]  next_pin_oe;
	logic                        wr_ctrl;
	logic                        wr_dir;
	logic                        wr_data;
	logic                        wr_csd;
	logic [`AOAD_DATA_W-1:0]     status_word;

	assign ae_field = address_pin_enable_ctrl[`AOAD_AE_MSB:`AOAD_AE_LSB];

	// Thermometer decode of the enable count
	for (genvar i = 0; i < `AOAD_NUM_APINS; i++) begin : g_apin
		assign addr_en[i]      = (4'(i) < ae_field) || (ae_field == `AOAD_AE_ALL);
		// Enabled pin ignores its direction bit; others fall back to the port
		assign next_pin_out[i] = addr_en[i] ? ext_bus.addr[`AOAD_APIN_BASE + i] : port_data[i];
		assign next_pin_oe[i]  = addr_en[i] || port_dir[i];
	end

	assign next_apin = '{out: next_pin_out, oe: next_pin_oe};

	aoad_area_decode u_area (
		.bus  (ext_bus),
		.area (area),
		.cs_n (next_cs_n)
	);

	// APB decode
	assign setup   = psel && !penable;
	assign wr_fire = psel && penable && pready && pwrite && !pslverr;

	// One strobe per register; STATUS has none, so writes to it drop silently
	assign wr_ctrl = wr_fire && (paddr == `AOAD_OFS_ADDR_EN);
	assign wr_dir  = wr_fire && (paddr == `AOAD_OFS_PORT_DIR);
	assign wr_data = wr_fire && (paddr == `AOAD_OFS_PORT_DATA);
	assign wr_csd  = wr_fire && (paddr == `AOAD_OFS_CS_DIR);

	// Live pin and decode view; read-only, sampled at the setup edge
	always_comb begin
		status_word                                      = '0;
		status_word[`AOAD_NUM_APINS-1:0]                 = apin.oe;
		status_word[`AOAD_ST_AREA_MSB:`AOAD_ST_AREA_LSB] = area;
		status_word[`AOAD_ST_ACC_BIT]                    = ext_bus.access;
		status_word[`AOAD_ST_CS_MSB:`AOAD_ST_CS_LSB]     = cs_pin_n;
	end

	always_comb begin
		hit        = 1'b1;
		next_rdata = 32'h0000_0000;
		case (paddr)
			`AOAD_OFS_ADDR_EN: begin
				next_rdata[`AOAD_CTRL_W-1:0] = address_pin_enable_ctrl;
			end
			`AOAD_OFS_PORT_DIR: begin
				next_rdata[`AOAD_NUM_APINS-1:0] = port_dir;
			end
			`AOAD_OFS_PORT_DATA: begin
				next_rdata[`AOAD_NUM_APINS-1:0] = port_data;
			end
			`AOAD_OFS_CS_DIR: begin
				next_rdata[`AOAD_NUM_CS-1:0] = cs_dir;
			end
			`AOAD_OFS_STATUS: begin
				next_rdata = status_word;
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// Answer in the first access cycle, never with wait states
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
		end else begin
			pready <= setup;
		end
	end

	// Error only for unmapped offsets
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= setup && !hit;
		end
	end

	// Idle data held at zero so a stray sample reads nothing
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= '0;
		end else if (setup && !pwrite) begin
			prdata <= next_rdata;
		end else begin
			prdata <= '0;
		end
	end

	// Strap loads once after release; an async load would need a port value
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_done              <= 1'b0;
			address_pin_enable_ctrl <= `AOAD_CTRL_RST;
		end else if (!strap_done) begin
			strap_done <= 1'b1;
			if (op_mode == `AOAD_MODE_4 || op_mode == `AOAD_MODE_5) begin
				address_pin_enable_ctrl[`AOAD_AE_MSB:`AOAD_AE_LSB] <= `AOAD_AE_RST_ROM;
			end else begin
				address_pin_enable_ctrl[`AOAD_AE_MSB:`AOAD_AE_LSB] <= `AOAD_AE_RST_NONE;
			end
		end else if (wr_ctrl) begin
			// Reserved upper bits are stored as written and expected zero
			address_pin_enable_ctrl <= pwdata[`AOAD_CTRL_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_dir <= '0;
		end else if (wr_dir) begin
			port_dir <= pwdata[`AOAD_NUM_APINS-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			port_data <= '0;
		end else if (wr_data) begin
			port_data <= pwdata[`AOAD_NUM_APINS-1:0];
		end
	end

	// Selects stay undriven until software opens them
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_dir <= '0;
		end else if (wr_csd) begin
			cs_dir <= pwdata[`AOAD_NUM_CS-1:0];
		end
	end

	// Registered pins: one cycle from address or field to the pad
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			apin <= '0;
		end else begin
			apin <= next_apin;
		end
	end

	// Selects idle high, so reset never strobes a memory
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_pin_n <= '1;
		end else begin
			cs_pin_n <= next_cs_n;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cs_pin_oe <= '0;
		end else begin
			cs_pin_oe <= cs_dir;
		end
	end

endmodule

`default_nettype wire

/* test/aoad_checker.sv */
// Port checker for the address output block.
// Assumes zero-wait APB and registered pins.
`timescale 1ns/1ps
`default_nettype none
module aoad_checker
	import aoad_pkg::*;
(
	input wire logic          core_clk,
	input wire logic          arst_n,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [11:0]   paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	input wire aoad_ext_bus_t ext_bus,
	input wire aoad_apin_t    apin,
	input wire logic [5:0]    cs_pin_n,
	input wire logic [5:0]    cs_pin_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wr;
		psel && penable && pready && pwrite;
	endsequence
	AST_PREADY: assert property (s_setup |=> pready) else $error("no ready");
	AST_READY_SEL: assert property (pready |-> psel && penable) else $error("stray ready");
	AST_IDLE: assert property (!psel |=> !pready) else $error("idle ready");
	AST_SLVERR: assert property (s_setup ##0 paddr > 12'h010 |=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped accepted");
	AST_CS_IDLE: assert property (!ext_bus.access |=> cs_pin_n == 6'h3f) else $error("select low");
	AST_CS_AREA: assert property (ext_bus.access |=> cs_pin_n == ~(6'h01 << $past(ext_bus.addr[23:21])))
		else $error("wrong select");
	AST_CS_OE: assert property (s_wr ##0 paddr == 12'h00c |-> ##2 cs_pin_oe == $past(pwdata[5:0], 2))
		else $error("select enable");
	AST_ALL_EN: assert property (s_wr ##0 paddr == 12'h000 && pwdata[3:0] == 4'hf |-> ##2 apin.oe == 16'hffff)
		else $error("not all driven");
endmodule
bind aoad_top aoad_checker u_aoad_checker (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .ext_bus, .apin, .cs_pin_n, .cs_pin_oe);
`default_nettype wire

/* test/aoad_ext_mem.sv */
// Board side of the address and select pins.
// Assumes a pull-up on every line.
`timescale 1ns/1ps
`default_nettype none
module aoad_ext_mem
	import aoad_pkg::*;
(
	input  wire aoad_apin_t apin,
	input  wire logic [5:0] cs_pin_n,
	input  wire logic [5:0] cs_pin_oe,
	output logic [15:0]     bus_lvl,
	output logic [5:0]      cs_lvl
);
	// Pull-up, so a released line never shows its last value
	assign bus_lvl = apin.out | ~apin.oe;
	assign cs_lvl  = cs_pin_n | ~cs_pin_oe;
endmodule
`default_nettype wire

/* test/address_output_area_decode_tb_top.sv */
// Bench for the address output block.
// Assumes the design sources and the pin model.
`timescale 1ns/1ps
`default_nettype none
module address_output_area_decode_tb_top
	import aoad_pkg::*;
;
	logic          core_clk, arst_n, psel, penable, pwrite, pready, pslverr, e;
	logic [2:0]    op_mode;
	logic [11:0]   paddr;
	logic [31:0]   pwdata, prdata, r;
	logic [15:0]   dir, dat, bus_lvl;
	logic [5:0]    csd, csn, cse, cs_pin_n, cs_pin_oe, cs_lvl;
	aoad_ext_bus_t ext_bus;
	aoad_apin_t    apin;
	int            errors, compares, f;
	aoad_top u_aoad_top (.core_clk, .arst_n, .op_mode, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ext_bus, .apin, .cs_pin_n, .cs_pin_oe);
	aoad_ext_mem u_aoad_ext_mem (.apin, .cs_pin_n, .cs_pin_oe, .bus_lvl, .cs_lvl);
	initial begin
		core_clk = 0;
		forever #2 core_clk = ~core_clk;
	end
	task chk(string nm, logic [31:0] got, logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task give_verdict;
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task apb(logic w, logic [11:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 9);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		if (pready !== 1'h1) begin
			errors++;
			give_verdict();
		end
	endtask
	// Pins the field enables carry the address; the rest fall back to the port
	function logic [15:0] pins(int f, logic [15:0] dir, logic [15:0] dat, logic [23:0] a);
		for (int i = 0; i < 16; i++)
			pins[i] = (i < f || f == 15) ? a[8+i] : (dir[i] ? dat[i] : 1'h1);
	endfunction
	// Status model: driven pins, area, access flag and select levels
	function logic [31:0] stat(int f, logic [15:0] dir, logic [5:0] csn, aoad_ext_bus_t b);
		stat = 32'h0000_0000;
		for (int i = 0; i < 16; i++)
			stat[i] = i < f || f == 15 || dir[i];
		stat[18:16] = b.addr[23:21];
		stat[19] = b.access;
		stat[25:20] = csn;
	endfunction
	initial begin
		{arst_n, psel, penable, pwrite, paddr, pwdata, dir, dat, csd, op_mode} = '0;
		ext_bus = '0;
		void'($urandom(32'h0000_a1b7));
		for (int m = 4; m < 8; m++) begin
			arst_n <= 0;
			op_mode <= 3'(m);
			repeat (6) @(posedge core_clk);
			arst_n <= 1;
			f = m < 6 ? 13 : 0;
			apb(0, 12'h000, 0);
			chk("field", r, f);
			chk("pins", bus_lvl, pins(f, dir, dat, ext_bus.addr));
		end
		for (int k = 0; k < 40; k++) begin
			f = k < 16 ? k : $urandom_range(15);
			dir = 16'($urandom);
			dat = 16'($urandom);
			csd = 6'($urandom);
			apb(1, 12'h000, 32'(f));
			apb(1, 12'h004, {16'h0000, dir});
			apb(1, 12'h008, {16'h0000, dat});
			apb(1, 12'h00c, {26'h0, csd});
			ext_bus <= aoad_ext_bus_t'(25'($urandom));
			repeat (3) @(posedge core_clk);
			apb(0, 12'h000, 0);
			chk("field", r, f);
			chk("field error", e, 0);
			chk("pins", bus_lvl, pins(f, dir, dat, ext_bus.addr));
			// Six-bit model, so areas 6 and 7 shift out and leave all high
			csn = ~(ext_bus.access ? 6'h01 << ext_bus.addr[23:21] : 6'h00);
			cse = csn | ~csd;
			chk("cs", cs_lvl, cse);
			apb(0, 12'h010, 0);
			chk("status", r, stat(f, dir, csn, ext_bus));
		end
		apb(0, 12'h014, 0);
		chk("unmapped data", r, 0);
		chk("unmapped error", e, 1);
		give_verdict();
	end
endmodule
`default_nettype wire
